// file: rtl/sfwe_ctrl.sv
// Purpose: Write-enable latch, erase sequencing and program/erase suspend control
// Assumes: Host keeps select high at least 4 system clocks between frames
// Notes:   Lane capture runs on the serial clock; decoding runs on clk_sys

`timescale 1ns/1ns

module sfwe_ctrl
  import sfwe_pkg::*;
#(
  parameter int NUM_SECTORS = 128,
  parameter logic [7:0] OPC_SUBSECTOR_ERASE = 8'h21,
  parameter logic [7:0] OPC_SECTOR_ERASE = 8'h22,
  parameter logic [7:0] OPC_FULL_ERASE = 8'h23,
  parameter logic [7:0] OPC_SUSPEND = 8'h24,
  parameter logic [7:0] OPC_RESUME = 8'h25,
  parameter logic [7:0] OPC_PROGRAM = 8'h26,
  parameter logic [31:0] SUBSECTOR_ERASE_CYC = 32'h0000_C350,
  parameter logic [31:0] SECTOR_ERASE_CYC = 32'h0004_93E0,
  parameter logic [31:0] FULL_ERASE_CYC = 32'h0098_9680,
  parameter logic [31:0] PROGRAM_CYC = 32'h0000_61A8
) (
  // System clock and power-up reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial link from the host
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] serial_lane,
  // Configuration and array feedback
  input wire logic [1:0] proto_mode,
  input wire logic [NUM_SECTORS-1:0] lock_map,
  input wire logic array_fault,
  // Status
  output logic wel,
  output logic wip,
  output logic [7:0] flag_status,
  output logic ers_suspended,
  output logic [ADDR_BITS-1:0] ers_susp_addr,
  output logic reg_write_ok
);

  localparam int SEC_W = $clog2(NUM_SECTORS);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_SECTORS < 2 || SECTOR_LSB + SEC_W > ADDR_BITS) begin : g_bad_sectors
    $error("sfwe_ctrl: NUM_SECTORS does not fit the address");
  end
  if (SUBSECTOR_ERASE_CYC <= SUSP_LAT_ERS_CYC || PROGRAM_CYC <= SUSP_LAT_PGM_CYC) begin : g_bad_t
    $error("sfwe_ctrl: operation times must exceed the suspend latency");
  end

  // ----------------------------------------------------------------
  // Serial clock domain: lane capture
  // ----------------------------------------------------------------
  logic frame_open;
  logic [5:0] edge_cnt;
  logic [3:0] lane_mem [MAX_EDGES];

  // Frame marker, cleared by select itself since the clock stops with it
  always_ff @(posedge sck or posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      frame_open <= 1'b0;
    end else if (cs_n) begin
      frame_open <= 1'b0;
    end else begin
      frame_open <= 1'b1;
    end
  end

  // Edge count survives select rise so the system side can read it
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt <= 6'h00;
    end else if (!cs_n) begin
      if (!frame_open) begin
        edge_cnt <= 6'h01;
      end else if (edge_cnt != 6'h3F) begin
        edge_cnt <= edge_cnt + 6'h01;
      end
    end
  end

  // Lane samples stored by edge index; edges past the store are dropped
  always_ff @(posedge sck) begin
    if (!cs_n) begin
      if (!frame_open) begin
        lane_mem[0] <= serial_lane;
      end else if (edge_cnt < 6'(MAX_EDGES)) begin
        lane_mem[edge_cnt[4:0]] <= serial_lane;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame end detection on the system clock
  // ----------------------------------------------------------------
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic frame_end;

  // Select crosses as a level; count and lanes are static once it is high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  assign frame_end = cs_sync & ~cs_prev;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] get_opcode(input logic [1:0] mode);
    logic [7:0] op;
    op = 8'h00;
    for (int i = 0; i < 8; i++) begin
      case (mode)
        PROTO_DUAL: op[7-i] = lane_mem[i/2][1-(i%2)];
        PROTO_QUAD: op[7-i] = lane_mem[i/4][3-(i%4)];
        default: op[7-i] = lane_mem[i][0];
      endcase
    end
    return op;
  endfunction

  function automatic logic [ADDR_BITS-1:0] get_addr();
    logic [ADDR_BITS-1:0] a;
    a = '0;
    for (int i = 0; i < ADDR_BITS; i++) begin
      a[ADDR_BITS-1-i] = lane_mem[OPC_BITS+i][0];
    end
    return a;
  endfunction

  function automatic logic [SEC_W-1:0] sector_of(input logic [ADDR_BITS-1:0] a);
    return a[SECTOR_LSB +: SEC_W];
  endfunction

  logic [8:0] frame_bits;
  logic [7:0] opcode;
  logic [ADDR_BITS-1:0] frame_addr;
  logic is_ext;
  logic cmd_wren;
  logic cmd_wrdi;
  logic cmd_sse;
  logic cmd_se;
  logic cmd_be;
  logic cmd_susp;
  logic cmd_res;
  logic cmd_pgm;

  // Bits on the wire depend on how many lanes each edge carries
  always_comb begin
    case (proto_mode)
      PROTO_DUAL: frame_bits = {2'b00, edge_cnt, 1'b0};
      PROTO_QUAD: frame_bits = {1'b0, edge_cnt, 2'b00};
      default: frame_bits = {3'b000, edge_cnt};
    endcase
  end

  // Process form so the decode follows the stored lanes, not only the mode
  always_comb begin
    opcode = get_opcode(proto_mode);
    frame_addr = get_addr();
  end
  assign is_ext = (proto_mode == PROTO_EXT);

  // [R4] Lane width per protocol
  // [R3] Exact eight bits only
  assign cmd_wren = frame_end && opcode == OPC_WR_ENABLE && frame_bits == 9'(OPC_BITS);
  assign cmd_wrdi = frame_end && opcode == OPC_WR_DISABLE && frame_bits == 9'(OPC_BITS);
  // [R25] Parameterised opcodes
  // [R6] [R7] [R12] Opcode plus address
  assign cmd_sse = frame_end && is_ext && opcode == OPC_SUBSECTOR_ERASE
                   && frame_bits == 9'(ERASE_FRAME_BITS);
  assign cmd_se = frame_end && is_ext && opcode == OPC_SECTOR_ERASE
                  && frame_bits == 9'(ERASE_FRAME_BITS);
  // [R14] Opcode-only bulk erase
  assign cmd_be = frame_end && is_ext && opcode == OPC_FULL_ERASE
                  && frame_bits == 9'(OPC_BITS);
  // [R15] Single-opcode suspend
  assign cmd_susp = frame_end && is_ext && opcode == OPC_SUSPEND
                    && frame_bits == 9'(OPC_BITS);
  assign cmd_res = frame_end && is_ext && opcode == OPC_RESUME
                   && frame_bits == 9'(OPC_BITS);
  assign cmd_pgm = frame_end && is_ext && opcode == OPC_PROGRAM
                   && frame_bits >= 9'(PGM_MIN_BITS) && frame_bits[2:0] == 3'h0;

  // ----------------------------------------------------------------
  // Controller decisions
  // ----------------------------------------------------------------
  sfwe_state_t state;
  sfwe_kind_t cur_kind;
  sfwe_kind_t ers_kind;
  logic [31:0] remain;
  logic [31:0] lat_cnt;
  logic [31:0] ers_remain;
  logic [31:0] pgm_remain;
  logic [ADDR_BITS-1:0] cur_addr;
  logic pgm_susp;
  logic standby;
  logic erase_cmd;
  logic erase_prot;
  logic start_erase;
  logic prot_err;
  logic pgm_ok;
  logic pgm_hit_susp;
  logic pgm_prot;
  logic start_pgm;
  logic cur_is_pgm;
  logic susp_go;
  logic susp_late;
  logic susp_done;
  logic op_done;
  logic resume_pgm;
  logic resume_ers;
  logic [31:0] lat_need;
  logic [31:0] erase_len;

  assign standby = (state == ST_IDLE) && !ers_suspended && !pgm_susp;
  assign cur_is_pgm = (cur_kind == KIND_PGM);
  assign erase_cmd = cmd_sse | cmd_se | cmd_be;

  // [R13] [R14] Protected area check
  assign erase_prot = cmd_be ? |lock_map : lock_map[sector_of(frame_addr)];

  // [R9] Latch clear ignores erase
  // [R8] Start on select rise
  assign start_erase = erase_cmd && standby && wel && !erase_prot;
  assign prot_err = erase_cmd && standby && wel && erase_prot;

  always_comb begin
    case (1'b1)
      cmd_sse: erase_len = SUBSECTOR_ERASE_CYC;
      cmd_se: erase_len = SECTOR_ERASE_CYC;
      default: erase_len = FULL_ERASE_CYC;
    endcase
  end

  // [R20] Program allowed outside the suspended erase area
  assign pgm_ok = cmd_pgm && state == ST_IDLE && !pgm_susp && wel;
  assign pgm_hit_susp = ers_suspended && (ers_kind == KIND_SSE
    ? frame_addr[ADDR_BITS-1:SUBSECTOR_LSB] == ers_susp_addr[ADDR_BITS-1:SUBSECTOR_LSB]
    : sector_of(frame_addr) == sector_of(ers_susp_addr));
  assign pgm_prot = lock_map[sector_of(frame_addr)];
  assign start_pgm = pgm_ok && !pgm_hit_susp && !pgm_prot;

  assign lat_need = cur_is_pgm ? SUSP_LAT_PGM_CYC : SUSP_LAT_ERS_CYC;
  // [R18] Too late to suspend: run to the end
  // Last busy cycle excluded: the operation ends there and the bit must stay clear
  assign susp_late = cmd_susp && state == ST_BUSY && remain <= lat_need && remain != 32'h1;
  assign susp_go = cmd_susp && state == ST_BUSY && remain > lat_need;
  assign susp_done = (state == ST_SWAIT) && lat_cnt == 32'h1;
  assign op_done = (state == ST_BUSY) && remain == 32'h1;

  // [R24] Newest suspension resumes first
  // [R23] Ignored with nothing suspended
  assign resume_pgm = cmd_res && state == ST_IDLE && pgm_susp;
  assign resume_ers = cmd_res && state == ST_IDLE && !pgm_susp && ers_suspended;

  // ----------------------------------------------------------------
  // Array controller state
  // ----------------------------------------------------------------
  // [R10] Busy until the timed count runs out
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      remain <= 32'h0;
      lat_cnt <= 32'h0;
      cur_kind <= KIND_PGM;
      cur_addr <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_erase) begin
            state <= ST_BUSY;
            remain <= erase_len;
            cur_addr <= frame_addr;
            cur_kind <= cmd_sse ? KIND_SSE : (cmd_se ? KIND_SE : KIND_BE);
          end else if (start_pgm) begin
            state <= ST_BUSY;
            remain <= PROGRAM_CYC;
            cur_addr <= frame_addr;
            cur_kind <= KIND_PGM;
          end else if (resume_pgm) begin
            state <= ST_BUSY;
            remain <= pgm_remain;
            cur_kind <= KIND_PGM;
          end else if (resume_ers) begin
            state <= ST_BUSY;
            remain <= ers_remain;
            cur_addr <= ers_susp_addr;
            cur_kind <= ers_kind;
          end
        end
        ST_BUSY: begin
          if (susp_go) begin
            state <= ST_SWAIT;
            lat_cnt <= lat_need;
          end else if (op_done) begin
            state <= ST_IDLE;
          end
          remain <= remain - 32'h1;
        end
        ST_SWAIT: begin
          // Array work stops while the latency elapses
          lat_cnt <= lat_cnt - 32'h1;
          if (susp_done) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Suspended contexts
  // ----------------------------------------------------------------
  // [R19] Nothing suspended after power-up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ers_suspended <= 1'b0;
      pgm_susp <= 1'b0;
      ers_remain <= 32'h0;
      pgm_remain <= 32'h0;
      ers_kind <= KIND_SSE;
      ers_susp_addr <= '0;
    end else begin
      // [R15] Held until resume
      if (susp_done && cur_is_pgm) begin
        pgm_susp <= 1'b1;
        pgm_remain <= remain;
      end else if (resume_pgm) begin
        pgm_susp <= 1'b0;
      end
      if (susp_done && !cur_is_pgm) begin
        ers_suspended <= 1'b1;
        ers_remain <= remain;
        ers_kind <= cur_kind;
        ers_susp_addr <= cur_addr;
      end else if (resume_ers) begin
        ers_suspended <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write-enable latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wel <= 1'b0;
    end else if (start_erase || start_pgm) begin
      // [R10] Cleared whatever the outcome
      // [R11] Timeout leaves it cleared
      wel <= 1'b0;
    end else if (state == ST_IDLE && cmd_wren) begin
      // [R1] Set latch
      wel <= 1'b1;
    end else if (state == ST_IDLE && cmd_wrdi) begin
      // [R2] Clear latch
      wel <= 1'b0;
    end
    // Refused erases and programs leave the latch alone
  end

  // ----------------------------------------------------------------
  // Flag status register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // [R19] Power-up value
      flag_status <= FLAG_RESET;
    end else begin
      if (start_erase || start_pgm || resume_pgm || resume_ers) begin
        // [R23] Controller busy again
        flag_status[FL_READY] <= 1'b0;
      end else if (op_done || susp_done) begin
        // [R16] [R17] Ready once suspended
        flag_status[FL_READY] <= 1'b1;
      end
      // [R13] [R14] Protection error
      if (prot_err) begin
        flag_status[FL_PROT] <= 1'b1;
        flag_status[FL_ERS_ERR] <= 1'b1;
      end
      // [R21] Suspended-sector program
      if (pgm_ok && (pgm_hit_susp || pgm_prot)) begin
        flag_status[FL_PGM_ERR] <= 1'b1;
        flag_status[FL_PROT] <= pgm_prot | flag_status[FL_PROT];
      end
      // [R11] Erase timeout flag; a program timeout sets the program-error flag
      if (op_done && array_fault) begin
        if (cur_is_pgm) begin
          flag_status[FL_PGM_ERR] <= 1'b1;
        end else begin
          flag_status[FL_ERS_ERR] <= 1'b1;
        end
      end
      // [R16] [R17] [R18] Suspend bits
      if ((susp_go || susp_late) && cur_is_pgm) begin
        flag_status[FL_PGM_SUSP] <= 1'b1;
      end else if ((op_done && cur_is_pgm) || resume_pgm) begin
        flag_status[FL_PGM_SUSP] <= 1'b0;
      end
      if ((susp_go || susp_late) && !cur_is_pgm) begin
        flag_status[FL_ERS_SUSP] <= 1'b1;
      end else if ((op_done && !cur_is_pgm) || resume_ers) begin
        flag_status[FL_ERS_SUSP] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  // Progress shows during the latency too, since the controller is still in ST_SWAIT
  assign wip = (state != ST_IDLE);

  // [R22] Register writes open in standby and suspend
  assign reg_write_ok = (state == ST_IDLE);

endmodule // sfwe_ctrl

// file: rtl/sfwe_pkg.sv
// Purpose: Constants for the serial flash write-enable, erase and suspend control
// Assumes: System clock of 250 MHz; flag status register layout as below
// Notes:   Opcodes other than write enable/disable are module parameters
//
// Behaviour
// [R1] Write-enable opcode 06h sets the latch when select rises after eight bits.
// [R2] Write-disable opcode 04h clears the latch when select rises after eight bits.
// [R3] Any other bit count at select rise: no execution, no flags, latch unchanged.
// [R4] Enable/disable opcodes arrive on lane 0, lanes 1:0 or lanes 3:0 per protocol.
// [R5] Host sets the latch before every program, erase or register write.
// [R6] Subsector erase: opcode then three address bytes; any address selects it.
// [R7] Sector erase: opcode then three address bytes; whole sector becomes FFh.
// [R8] Erase starts only when select rises after the last complete byte.
// [R9] Erase with latch clear is ignored and sets no failure flags.
// [R10] Erase holds write-in-progress, clears the latch, drops progress at the end.
// [R11] Erase timeout clears the latch and sets the erase-error flag.
// [R12] Select raised at a wrong point: erase not run, no flags, latch kept.
// [R13] Erase to a protected area is refused; latch kept; flags 1 and 5 set.
// [R14] Bulk erase is opcode only; refused with flags 1 and 5 if any lock.
// [R15] Suspend is one opcode; suspended state lasts until a resume.
// [R16] Suspend in program sets flag 2 at once, flag 7 after the latency.
// [R17] Suspend in erase sets flag 6 at once, flag 7 after the latency.
// [R18] If less time remains than the latency, finish and clear flag 2 or 6.
// [R19] Suspend state is lost at power-up; flag status powers up as 80h.
// [R20] During erase suspend other sectors work; suspended sector reads are undefined.
// [R21] Program into the erase-suspended sector is ignored, sets flag 4, latch kept.
// [R22] Lock and volatile configuration writes stay allowed during erase suspend.
// [R23] Resume sets write-in-progress, clears flag 7; ignored when nothing is suspended.
// [R24] One nesting level: first resume restarts program, second restarts erase.
// [R25] Erase, suspend and resume opcodes are decoder parameters.

package sfwe_pkg;

  // ----------------------------------------------------------------
  // Fixed opcodes and frame lengths
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_WR_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WR_DISABLE = 8'h04;
  localparam int OPC_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int ERASE_FRAME_BITS = OPC_BITS + ADDR_BITS;
  localparam int PGM_MIN_BITS = ERASE_FRAME_BITS + 8;
  localparam int MAX_EDGES = 32;

  // ----------------------------------------------------------------
  // Flag status register layout and reset value
  // ----------------------------------------------------------------
  localparam int FL_READY = 7;
  localparam int FL_ERS_SUSP = 6;
  localparam int FL_ERS_ERR = 5;
  localparam int FL_PGM_ERR = 4;
  localparam int FL_PGM_SUSP = 2;
  localparam int FL_PROT = 1;
  localparam logic [7:0] FLAG_RESET = 8'h80;

  // ----------------------------------------------------------------
  // Address map of the array
  // ----------------------------------------------------------------
  localparam int SECTOR_LSB = 16;
  localparam int SUBSECTOR_LSB = 12;

  // ----------------------------------------------------------------
  // Suspend latency
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SUSP_LAT_PGM_US = 7;
  localparam int SUSP_LAT_ERS_US = 15;
  localparam logic [31:0] SUSP_LAT_PGM_CYC = 32'(SUSP_LAT_PGM_US * CLK_MHZ);
  localparam logic [31:0] SUSP_LAT_ERS_CYC = 32'(SUSP_LAT_ERS_US * CLK_MHZ);

  // ----------------------------------------------------------------
  // Protocol modes, operation kinds, controller states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PROTO_EXT = 2'h0,
    PROTO_DUAL = 2'h1,
    PROTO_QUAD = 2'h2
  } sfwe_proto_t;

  typedef enum logic [1:0] {
    KIND_PGM = 2'h0,
    KIND_SSE = 2'h1,
    KIND_SE = 2'h2,
    KIND_BE = 2'h3
  } sfwe_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_SWAIT = 3'b100
  } sfwe_state_t;

endpackage

// file: dv/sfwe_host.sv
// Purpose: Host controller model driving select, serial clock and lanes
// Assumes: Serial clock of 6 ns runs only inside a frame
// Notes:   Lanes not in use, or released, toggle so no stale value lingers

`timescale 1ns/1ns

module sfwe_host (
  // Serial link to the device
  output logic sck,
  output logic cs_n,
  output logic [3:0] serial_lane
);
  // Idle link: select high, clock parked low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    serial_lane = 4'hA;
  end

  task automatic frame(input logic [39:0] d, input int n, input int k);
    int b;
    b = n - 1;
    #1 cs_n = 1'b0;
    for (int e = 0; e < n / k; e++) begin
      serial_lane = ~serial_lane;
      for (int j = 0; j < k; j++) begin
        serial_lane[k-1-j] = d[b];
        b--;
      end
      #3 sck = 1'b1;
      #3 sck = 1'b0;
    end
    #3 cs_n = 1'b1;
    // Released lanes show the inverse, not the last bit
    serial_lane = ~serial_lane;
    #40;
  endtask
endmodule // sfwe_host

// file: dv/sfwe_ctrl_monitor.sv
// Purpose: Port-level checks of latch, progress and flag behaviour
// Assumes: Single clk_sys domain for all watched outputs
// Notes:   Latency window allows two cycles of sync slack

`timescale 1ns/1ns

module sfwe_ctrl_monitor
  import sfwe_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link and array inputs
  input wire logic cs_n,
  input wire logic array_fault,
  // Status outputs
  input wire logic wel,
  input wire logic wip,
  input wire logic [7:0] flag_status,
  input wire logic ers_suspended,
  input wire logic [23:0] ers_susp_addr,
  input wire logic reg_write_ok
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [15:0] lat_cnt;

  // Cycles spent busy with an erase suspend pending
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lat_cnt <= '0;
    end else if (flag_status[FL_ERS_SUSP] && wip) begin
      lat_cnt <= lat_cnt + 16'h0001;
    end else begin
      lat_cnt <= '0;
    end
  end

  a_ready_not_busy: assert property (flag_status[FL_READY] == !wip)
    else $error("ready flag disagrees with progress");
  a_start_clears_wel: assert property ($rose(wip) && !$past(ers_suspended)
    && !$past(flag_status[FL_PGM_SUSP]) |-> !wel) else $error("latch set at start");
  a_wel_after_frame: assert property (!$stable(wel) |-> $past(cs_n, 3))
    else $error("latch moved without frame end");
  a_susp_entry: assert property ($rose(ers_suspended) |-> flag_status[FL_ERS_SUSP]
    && !wip && lat_cnt + 2 >= SUSP_LAT_ERS_CYC[15:0]
    && lat_cnt <= SUSP_LAT_ERS_CYC[15:0] + 2) else $error("bad suspend entry");
  a_resume_clears: assert property ($fell(ers_suspended)
    |-> wip && !flag_status[FL_ERS_SUSP]) else $error("bad resume");
  a_prot_keeps_wel: assert property ($rose(flag_status[FL_PROT]) |-> $stable(wel)
    && !wip && (flag_status[FL_ERS_ERR] || flag_status[FL_PGM_ERR]))
    else $error("bad protection refusal");
  a_fault_sets_err: assert property ($fell(wip) && array_fault && $past(array_fault)
    && !ers_suspended && !flag_status[FL_PGM_SUSP]
    |-> flag_status[FL_ERS_ERR] || flag_status[FL_PGM_ERR]) else $error("fault lost");
  a_susp_addr_held: assert property (ers_suspended && $past(ers_suspended)
    |-> $stable(ers_susp_addr)) else $error("suspended address moved");
  a_regwr_idle: assert property (reg_write_ok == !wip)
    else $error("register write gate wrong");

  c_suspend: cover property ($rose(ers_suspended));
  c_prot: cover property ($rose(flag_status[FL_PROT]));
  c_fault: cover property ($fell(wip) && flag_status[FL_ERS_ERR]);
  c_pgm_susp: cover property ($rose(flag_status[FL_PGM_SUSP]));
endmodule // sfwe_ctrl_monitor

bind sfwe_ctrl sfwe_ctrl_monitor i_mon (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n),
  .array_fault(array_fault), .wel(wel), .wip(wip), .flag_status(flag_status),
  .ers_suspended(ers_suspended), .ers_susp_addr(ers_susp_addr),
  .reg_write_ok(reg_write_ok));

// file: dv/tb.sv
// Purpose: Self-checking bench for the write/erase/suspend control
// Assumes: Short erase counts so a run stays small
// Notes:   Expected flags kept in an integer; expected latch given in each check

`timescale 1ns/1ns

module tb;
  import sfwe_pkg::*;
  logic clk_sys, rst_n, sck, cs_n, array_fault, wel, wip, ers_suspended, reg_write_ok;
  logic [3:0] serial_lane;
  logic [1:0] proto_mode;
  logic [7:0] lock_map, flag_status;
  logic [23:0] ers_susp_addr, m_addr;
  logic [31:0] seed = 32'h7BA749E4;
  int mismatches, checked, m_flag, m_wel;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: %h not %h", $time, a, b); end end

  sfwe_ctrl #(.NUM_SECTORS(8), .SUBSECTOR_ERASE_CYC(32'h0000_0FA0),
    .SECTOR_ERASE_CYC(32'h0000_0FA0), .FULL_ERASE_CYC(32'h0000_0FA0),
    .PROGRAM_CYC(32'h0000_07D0)) i_sfwe_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
    .sck(sck), .cs_n(cs_n), .serial_lane(serial_lane), .proto_mode(proto_mode),
    .lock_map(lock_map), .array_fault(array_fault), .wel(wel), .wip(wip),
    .flag_status(flag_status), .ers_suspended(ers_suspended),
    .ers_susp_addr(ers_susp_addr), .reg_write_ok(reg_write_ok));
  sfwe_host i_sfwe_host (.sck(sck), .cs_n(cs_n), .serial_lane(serial_lane));

  // System clock, 4 ns
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Frame, then the fixed answer delay of the decoder
  task automatic cmd(input logic [39:0] d, input int n, input int k = 1);
    i_sfwe_host.frame(d, n, k);
    repeat (6) @(negedge clk_sys);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 6000 && wip === 1'b1; i++) @(negedge clk_sys);
  endtask

  task automatic erase(input logic [7:0] op, input logic [2:0] sec);
    m_addr = {5'h00, sec, 16'(rnd())};
    cmd({op, m_addr}, 32);
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: whole run is near 24k cycles
  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    proto_mode = 2'h0;
    lock_map = 8'h00;
    array_fault = 1'b0;
    m_flag = 'h80;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    `CHK(flag_status, 8'(m_flag))
    for (int k = 0; k < 3; k++) begin
      proto_mode = 2'(k);
      cmd(32'h06, 8, 1 << k);
      `CHK(wel, 1'b1)
      cmd(32'h04, 8, 1 << k);
      `CHK(wel, 1'b0)
    end
    proto_mode = 2'h0;
    erase(8'h22, 3'h1);
    `CHK(wip, 1'b0)
    `CHK(flag_status, 8'(m_flag))
    // Latch set, then frames of 7 and 31 bits that must leave it set
    cmd(32'h06, 8);
    cmd(32'h02, 7);
    `CHK(wel, 1'b1)
    cmd({8'h22, 24'h01_2345} >> 1, 31);
    `CHK(wip, 1'b0)
    `CHK(wel, 1'b1)
    erase(8'h22, 3'h5);
    m_flag &= ~'h80;
    `CHK(wip, 1'b1)
    `CHK(wel, 1'b0)
    wait_idle();
    m_flag |= 'h80;
    `CHK(flag_status, 8'(m_flag))
    array_fault = 1'b1;
    cmd(32'h06, 8);
    erase(8'h21, 3'h2);
    wait_idle();
    array_fault = 1'b0;
    m_flag |= 'h20;
    `CHK(flag_status, 8'(m_flag))
    `CHK(wel, 1'b0)
    lock_map = 8'h08;
    cmd(32'h06, 8);
    erase(8'h22, 3'h3);
    m_flag |= 'h22;
    `CHK(flag_status, 8'(m_flag))
    `CHK(wel, 1'b1)
    cmd(32'h23, 8);
    `CHK(wip, 1'b0)
    `CHK(wel, 1'b1)
    lock_map = 8'h00;
    erase(8'h22, 3'h6);
    cmd(32'h24, 8);
    m_flag = (m_flag | 'h40) & ~'h80;
    `CHK(flag_status, 8'(m_flag))
    `CHK(wip, 1'b1)
    wait_idle();
    m_flag |= 'h80;
    `CHK(flag_status, 8'(m_flag))
    `CHK(ers_suspended, 1'b1)
    `CHK(ers_susp_addr, m_addr)
    `CHK(reg_write_ok, 1'b1)
    // Program into the suspended sector, then into another one, nested
    cmd(32'h06, 8);
    cmd({8'h26, m_addr, 8'h5A}, 40);
    m_flag |= 'h10;
    `CHK(flag_status, 8'(m_flag))
    `CHK(wel, 1'b1)
    cmd({8'h26, 5'h00, 3'h1, 16'(rnd()), 8'hA5}, 40);
    m_flag &= ~'h80;
    `CHK(wip, 1'b1)
    `CHK(wel, 1'b0)
    cmd(32'h24, 8);
    m_flag |= 'h04;
    `CHK(flag_status, 8'(m_flag))
    wait_idle();
    m_flag |= 'h80;
    `CHK(flag_status, 8'(m_flag))
    cmd(32'h25, 8);
    m_flag &= ~'h84;
    `CHK(flag_status, 8'(m_flag))
    `CHK(ers_suspended, 1'b1)
    wait_idle();
    m_flag |= 'h80;
    cmd(32'h25, 8);
    m_flag &= ~'hC0;
    `CHK(flag_status, 8'(m_flag))
    `CHK(wip, 1'b1)
    wait_idle();
    m_flag |= 'h80;
    cmd(32'h25, 8);
    `CHK(flag_status, 8'(m_flag))
    `CHK(wip, 1'b0)
    cmd(32'h06, 8);
    erase(8'h22, 3'h4);
    repeat (400) @(negedge clk_sys);
    cmd(32'h24, 8);
    wait_idle();
    `CHK(flag_status, 8'(m_flag))
    `CHK(ers_suspended, 1'b0)
    close_out();
  end
endmodule // tb
